// *** count_chain_pkg.sv ***
package count_chain_pkg;
  // readout geometry
  localparam int DIGITS = 8;
  localparam int MUX_DIGITS = 8;
  localparam int STEP_PULSES = 7;
  localparam logic [3:0] BCD_MAX = 4'h9;
  localparam logic [3:0] BCD_ZERO = 4'h0;
  // real-time clock divider
  localparam int REF_KHZ = 100;
  localparam int TICK_HZ = 10;
  localparam int RTC_DIV = REF_KHZ * 1000 / TICK_HZ;
  localparam logic [2:0] DIG_FIRST = 3'h0;
  // readout control states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_HELD = 3'b010,
    ST_SCAN = 3'b100
  } readout_state_t;
  // pulse-style processor controls
  typedef struct packed {
    logic capture;
    logic step;
    logic clear;
  } proc_ctl_t;
endpackage

// *** gated_decade_count_chain.sv ***
`timescale 1ns/1ps
// What this block does
// - route exactly one of two IF inputs, chosen by processor select
// - count the selected input only while the gate is active
// - first decade BCD valid only after counting stops and settles
// - first decade carry is visible at all times
// - second decade clocks third, third's outputs clock five-decade counter
// - eight BCD decades are read digit by digit after counting
// - readout points at first digit when reset pulse ends
// - capture strobe loads multiplex latches with the current count while the gate is closed
// - seven step pulses advance readout across the remaining seven digits
// - one shared reset clears every decade and the readout pointer but not the latches, asserted before each count
// - divide 100 kHz reference by ten thousand to give 10 Hz tick
module gated_decade_count_chain
  import count_chain_pkg::*;
#(
  parameter int RTC_DIVISOR = RTC_DIV
)
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic if_in_a,
  input wire logic if_in_b,
  input wire logic if_select,
  input wire logic gate,
  input wire logic ref_100k,
  input wire count_chain_pkg::proc_ctl_t ctl,
  output logic [3:0] first_bcd,
  output logic first_bcd_valid,
  output logic first_carry,
  output logic [3:0] mux_bcd,
  output logic [2:0] mux_digit,
  output logic rtc_tick
);
  import count_chain_pkg::*;

  // refuse a divisor the tick counter cannot serve
  if (RTC_DIVISOR < 2)
  begin : g_bad_divisor
    $error("divisor too small");
  end

  // three-stage synchronisers for pin inputs
  logic [2:0] sa, sb, sg, sr;
  logic [2:0] next_sa, next_sb, next_sg, next_sr;
  always_comb
  begin
    next_sa = {sa[1:0], if_in_a};
    next_sb = {sb[1:0], if_in_b};
    next_sg = {sg[1:0], gate};
    next_sr = {sr[1:0], ref_100k};
  end
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      sa <= 3'h0;
      sb <= 3'h0;
      sg <= 3'h0;
      sr <= 3'h0;
    end
    else if (clk_en)
    begin
      sa <= next_sa;
      sb <= next_sb;
      sg <= next_sg;
      sr <= next_sr;
    end
  end

  // agreed levels and rising edges of filtered pins
  logic fa, fb, fg, fr, fref_prev;
  logic [1:0] next_f;
  logic [1:0] f_ab_prev;
  logic gate_lvl, sel_rise, ref_rise;
  always_comb
  begin
    next_f = {(sa[1] == sa[2]) ? sa[2] : fa, (sb[1] == sb[2]) ? sb[2] : fb};
  end
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      fa <= 1'b0;
      fb <= 1'b0;
      fg <= 1'b0;
      fr <= 1'b0;
      f_ab_prev <= 2'h0;
      fref_prev <= 1'b0;
    end
    else if (clk_en)
    begin
      fa <= next_f[1];
      fb <= next_f[0];
      fg <= (sg[1] == sg[2]) ? sg[2] : fg;
      fr <= (sr[1] == sr[2]) ? sr[2] : fr;
      f_ab_prev <= {fa, fb};
      fref_prev <= fr;
    end
  end
  // pick one input only
  assign sel_rise = if_select ? (fb & ~f_ab_prev[0])
                              : (fa & ~f_ab_prev[1]);
  assign gate_lvl = fg;
  assign ref_rise = fr & ~fref_prev;

  // decade chain: one carry feeds the next stage
  logic [3:0] dec [DIGITS];
  logic [3:0] next_dec [DIGITS];
  logic [DIGITS:0] carry;
  assign carry[0] = sel_rise & gate_lvl;
  genvar gi;
  generate
    for (gi = 0; gi < DIGITS; gi++)
    begin : g_dec
      // wrap 9 to 0 and carry onward
      assign carry[gi+1] = carry[gi] & (dec[gi] == BCD_MAX);
      always_comb
      begin
        next_dec[gi] = dec[gi];
        if (ctl.clear)
          next_dec[gi] = BCD_ZERO;
        else if (carry[gi])
          next_dec[gi] = (dec[gi] == BCD_MAX) ? BCD_ZERO
                                              : dec[gi] + 4'h1;
      end
      always_ff @(posedge ref_clk)
      begin
        if (!rstn)
          dec[gi] <= BCD_ZERO;
        else if (clk_en)
          dec[gi] <= next_dec[gi];
      end
    end
  endgenerate

  // readout: latches, digit pointer and state
  readout_state_t st, next_st;
  logic [3:0] latch [MUX_DIGITS];
  logic [3:0] next_latch [MUX_DIGITS];
  logic [2:0] ptr, next_ptr;
  logic [3:0] next_mux;
  logic load;
  assign load = ctl.capture && !gate_lvl;
  always_comb
  begin
    next_st = st;
    next_ptr = ptr;
    case (st)
      ST_IDLE:
        if (load)
          next_st = ST_HELD;
      ST_HELD, ST_SCAN:
        if (ctl.step && ptr < 3'(STEP_PULSES))
        begin
          next_ptr = ptr + 3'h1;
          next_st = ST_SCAN;
        end
        else if (load)
        begin
          next_ptr = DIG_FIRST;
          next_st = ST_HELD;
        end
      default:
        next_st = ST_IDLE;
    endcase
    if (ctl.clear)
    begin
      next_ptr = DIG_FIRST;
      next_st = ST_IDLE;
    end
    next_mux = next_latch[next_ptr]; // shows freshly captured digit
  end
  generate
    for (gi = 0; gi < MUX_DIGITS; gi++)
    begin : g_lat
      // capture copies the live decade into its latch
      always_comb
      begin
        next_latch[gi] = latch[gi];
        if (load)
          next_latch[gi] = dec[gi];
      end
      always_ff @(posedge ref_clk)
      begin
        if (!rstn)
          latch[gi] <= BCD_ZERO;
        else if (clk_en)
          latch[gi] <= next_latch[gi];
      end
    end
  endgenerate
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      st <= ST_IDLE;
      ptr <= DIG_FIRST;
    end
    else if (clk_en)
    begin
      st <= next_st;
      ptr <= next_ptr;
    end
  end

  // real-time clock divider
  logic [$clog2(RTC_DIVISOR)-1:0] rtc_cnt, next_rtc_cnt;
  logic next_tick;
  always_comb
  begin
    next_rtc_cnt = rtc_cnt;
    next_tick = 1'b0;
    if (ref_rise)
    begin
      if (rtc_cnt == $bits(rtc_cnt)'(RTC_DIVISOR - 1))
      begin
        next_rtc_cnt = '0;
        next_tick = 1'b1;
      end
      else
        next_rtc_cnt = rtc_cnt + 1'b1;
    end
  end

  // registered outputs
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      rtc_cnt <= '0;
      rtc_tick <= 1'b0;
      first_bcd <= BCD_ZERO;
      first_bcd_valid <= 1'b0;
      first_carry <= 1'b0;
      mux_bcd <= BCD_ZERO;
      mux_digit <= DIG_FIRST;
    end
    else if (clk_en)
    begin
      rtc_cnt <= next_rtc_cnt;
      rtc_tick <= next_tick;
      first_bcd <= next_dec[0];
      first_bcd_valid <= !gate_lvl && !carry[0];
      first_carry <= carry[1];
      mux_bcd <= next_mux;
      mux_digit <= next_ptr;
    end
  end

  // checks
  property p_ptr_clear;
    @(posedge ref_clk) disable iff (!rstn)
    (clk_en && ctl.clear) |=> (mux_digit == DIG_FIRST);
  endproperty
  a_ptr_clear: assert property (p_ptr_clear)
    else $error("pointer not at first digit after clear");
  property p_zero;
    @(posedge ref_clk) disable iff (!rstn)
    (clk_en && ctl.clear) |=> (first_bcd == BCD_ZERO);
  endproperty
  a_zero: assert property (p_zero)
    else $error("first decade not cleared");
  property p_valid;
    @(posedge ref_clk) disable iff (!rstn)
    (clk_en && gate_lvl) |=> !first_bcd_valid;
  endproperty
  a_valid: assert property (p_valid)
    else $error("valid while gate open");
  property p_nogate;
    @(posedge ref_clk) disable iff (!rstn)
    (clk_en && !gate_lvl && !ctl.clear) |=> $stable(dec[0]);
  endproperty
  a_nogate: assert property (p_nogate)
    else $error("counted with gate closed");
  property p_bcd;
    @(posedge ref_clk) disable iff (!rstn)
    first_bcd <= BCD_MAX && mux_bcd <= BCD_MAX;
  endproperty
  a_bcd: assert property (p_bcd)
    else $error("digit outside BCD range");
  property p_step;
    @(posedge ref_clk) disable iff (!rstn)
    (clk_en && ctl.step && !ctl.clear && st != ST_IDLE
      && ptr < 3'(STEP_PULSES)) |=> (mux_digit == $past(ptr) + 3'h1);
  endproperty
  a_step: assert property (p_step)
    else $error("step did not advance digit");
  property p_load;
    @(posedge ref_clk) disable iff (!rstn)
    (clk_en && load && !ctl.step && !ctl.clear) |=>
      (mux_digit == DIG_FIRST && mux_bcd == $past(dec[0]));
  endproperty
  a_load: assert property (p_load)
    else $error("capture did not show first digit");
  property p_carry;
    @(posedge ref_clk) disable iff (!rstn)
    (clk_en && carry[0] && dec[0] == BCD_MAX) |=> first_carry;
  endproperty
  a_carry: assert property (p_carry)
    else $error("carry not shown");
  property p_tick;
    @(posedge ref_clk) disable iff (!rstn)
    rtc_tick |=> !rtc_tick;
  endproperty
  a_tick: assert property (p_tick)
    else $error("tick longer than one cycle");
  c_load: cover property (@(posedge ref_clk) clk_en && load);
  c_last: cover property (@(posedge ref_clk) mux_digit == 3'h7);
  c_tick: cover property (@(posedge ref_clk) rtc_tick);
endmodule

// *** pulse_source.sv ***
`timescale 1ns/1ps
// far-side pin driver: n clean pulses, 4 cycles per level, idle low
module pulse_source
(
  input wire logic ref_clk,
  input wire logic go,
  input wire logic [15:0] n,
  output logic pin,
  output logic busy
);
  initial pin = 1'b0;
  initial busy = 1'b0;
  // each level outlasts the pin synchronizer
  always @(posedge ref_clk)
  begin
    if (go)
    begin
      busy <= 1'b1;
      repeat (n)
      begin
        pin <= 1'b1;
        repeat (4) @(posedge ref_clk);
        pin <= 1'b0;
        repeat (4) @(posedge ref_clk);
      end
      busy <= 1'b0;
    end
  end
endmodule

// *** gated_decade_count_chain_bench.sv ***
`timescale 1ns/1ps
module gated_decade_count_chain_bench;
  import count_chain_pkg::*;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic if_select = 1'b0;
  logic gate = 1'b0;
  proc_ctl_t ctl = '0;
  logic go_a = 1'b0;
  logic go_b = 1'b0;
  logic go_r = 1'b0;
  logic [15:0] na = '0;
  logic [15:0] nb = '0;
  logic a_pin, b_pin, r_pin, a_busy, b_busy, r_busy;
  logic [3:0] first_bcd, mux_bcd;
  logic [2:0] mux_digit;
  logic first_bcd_valid, first_carry, rtc_tick;
  logic look = 1'b0;
  logic [11:0] notes[$];
  logic [11:0] obs, want;
  logic [3:0] last0 = 4'h0;
  assign obs = {first_bcd_valid, first_bcd, mux_digit, mux_bcd};
  int fails = 0;
  int n_tests = 0;
  int carries = 0;
  int ticks = 0;
  int n;
  // 125 MHz clock
  always #4 ref_clk = ~ref_clk;
  gated_decade_count_chain #(.RTC_DIVISOR(4)) uut (.ref_clk(ref_clk),
    .rstn(rstn), .clk_en(1'b1), .if_in_a(a_pin), .if_in_b(b_pin),
    .if_select(if_select), .gate(gate), .ref_100k(r_pin), .ctl(ctl),
    .first_bcd(first_bcd), .first_bcd_valid(first_bcd_valid),
    .first_carry(first_carry), .mux_bcd(mux_bcd), .mux_digit(mux_digit),
    .rtc_tick(rtc_tick));
  pulse_source src_a (.ref_clk(ref_clk), .go(go_a), .n(na), .pin(a_pin),
    .busy(a_busy));
  pulse_source src_b (.ref_clk(ref_clk), .go(go_b), .n(nb), .pin(b_pin),
    .busy(b_busy));
  pulse_source src_r (.ref_clk(ref_clk), .go(go_r), .n(16'h0028),
    .pin(r_pin), .busy(r_busy));
  task automatic check(input logic [11:0] seen, input logic [11:0] want);
    n_tests++;
    if (seen !== want)
    begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic stop_test();
    $display("compares %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // note the expected outputs, then flag the monitor
  task automatic expect_obs(input logic [11:0] want);
    notes.push_back(want);
    look <= 1'b1;
    @(posedge ref_clk);
    look <= 1'b0;
    @(posedge ref_clk);
  endtask
  // one-cycle processor control pulse, then let the answer settle
  task automatic pulse(input proc_ctl_t c);
    ctl <= c;
    @(posedge ref_clk);
    ctl <= '0;
    repeat (3) @(posedge ref_clk);
  endtask
  // bounded wait for the pin sources to finish
  task automatic wait_idle();
    int i = 0;
    repeat (2) @(posedge ref_clk);
    while ((a_busy || b_busy || r_busy) && i < 30000)
    begin
      i++;
      @(posedge ref_clk);
    end
    if (i == 30000)
    begin
      fails++;
      stop_test();
    end
  endtask
  // compare settled outputs with the oldest note; count pulses
  always @(posedge ref_clk)
  begin
    if (first_carry)
      carries++;
    if (rtc_tick)
      ticks++;
    if (look && notes.size() == 0)
      check(12'hFFF, 12'h000);
    else if (look)
      check(obs, notes.pop_front());
  end
  initial
  begin
    void'($urandom(32'h3DF06279));
    repeat (17) @(posedge ref_clk);
    expect_obs(12'h000);
    $display("reset test done");
    @(posedge ref_clk);
    rstn <= 1'b1;
    go_r <= 1'b1;
    @(posedge ref_clk);
    go_r <= 1'b0;
    for (int s = 0; s < 2; s++)
    begin
      if_select <= s[0];
      pulse(proc_ctl_t'(3'h1));
      expect_obs({8'h80, last0});
      n = 1200 + $urandom % 500;
      carries = 0;
      gate <= 1'b1;
      na <= s ? 16'(n / 3) : 16'(n);
      nb <= s ? 16'(n) : 16'(n / 3);
      repeat (8) @(posedge ref_clk);
      go_a <= 1'b1;
      go_b <= 1'b1;
      @(posedge ref_clk);
      go_a <= 1'b0;
      go_b <= 1'b0;
      wait_idle();
      repeat (8) @(posedge ref_clk);
      gate <= 1'b0;
      repeat (10) @(posedge ref_clk);
      check(12'(carries), 12'(n / 10));
      expect_obs({1'b1, 4'(n % 10), 3'h0, last0});
      pulse(proc_ctl_t'(3'h4));
      last0 = 4'(n % 10);
      for (int d = 0; d < 8; d++)
      begin
        want = {1'b1, 4'(n % 10), 3'(d), 4'((n / 10 ** d) % 10)};
        expect_obs(want);
        pulse(proc_ctl_t'(3'h2));
      end
      expect_obs(want);
      $display("count test %0d done", s);
    end
    check(12'(ticks), 12'h00A);
    check(12'(notes.size()), 12'h000);
    $display("tick test done");
    stop_test();
  end
endmodule
